//--- pkg/lrm_pkg.sv
/*
  Package for the lockup recovery manageability block: register map,
  field positions, reset values, timing counts and carrier types.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
`default_nettype none
package lrm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] LRM_CTRL_OFS = 12'h000;
  localparam logic [11:0] LRM_RELOAD_OFS = 12'h004;
  localparam logic [11:0] LRM_COUNT_OFS = 12'h008;
  localparam logic [11:0] LRM_FUNCDIS_OFS = 12'h00c;
  localparam logic [11:0] LRM_STATUS_OFS = 12'h010;
  localparam logic [11:0] LRM_MASK_OFS = 12'h014;
  localparam logic [11:0] LRM_KICK_OFS = 12'h018;
  localparam logic [11:0] LRM_STATE_OFS = 12'h01c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int LRM_CTRL_WDG_EN_BIT = 0;
  localparam int LRM_CTRL_INTR_SEL_BIT = 1;
  localparam int LRM_CTRL_FETCH_EN_BIT = 2;
  localparam logic [31:0] LRM_CTRL_RST = 32'h0000_0004;

  // ----------------------------------------------------------------
  // Status / mask bits (status bits sticky, write one to clear)
  // ----------------------------------------------------------------
  localparam int LRM_ST_WDG1_BIT = 0;
  localparam int LRM_ST_WDG2_BIT = 1;
  localparam int LRM_ST_FETCH_BIT = 2;
  localparam int LRM_ST_ECC_BIT = 3;
  localparam int LRM_ST_INTRUDE_BIT = 4;
  localparam int LRM_ST_WIDTH = 5;
  localparam logic [LRM_ST_WIDTH-1:0] LRM_MASK_RST = 5'h00;

  // ----------------------------------------------------------------
  // Function disable bits
  // ----------------------------------------------------------------
  localparam int LRM_FN_COUNT = 7;
  localparam logic [LRM_FN_COUNT-1:0] LRM_FUNCDIS_RST = 7'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LRM_CLK_MHZ = 100;
  localparam int LRM_WDG_RELOAD_MS = 10;
  localparam int LRM_WDG_RELOAD_CYC = LRM_WDG_RELOAD_MS * LRM_CLK_MHZ * 1000;
  localparam int LRM_FETCH_WAIT_MS = 50;
  localparam int LRM_FETCH_WAIT_CYC = LRM_FETCH_WAIT_MS * LRM_CLK_MHZ * 1000;
  localparam int LRM_RST_PULSE_CYC = 16;

  // ----------------------------------------------------------------
  // ECC response codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LRM_ECC_SMI = 2'h0,
    LRM_ECC_NMI = 2'h1,
    LRM_ECC_SERR = 2'h2,
    LRM_ECC_WDG = 2'h3
  } lrm_ecc_type;

  typedef struct packed {
    logic valid;
    lrm_ecc_type sel;
  } lrm_ecc_msg_type;

  typedef struct packed {
    logic smi;
    logic nmi;
    logic serr;
    logic wdg_irq;
  } lrm_irq_type;

  typedef enum logic [3:0] {
    LRM_WS_IDLE = 4'b0001,
    LRM_WS_FIRST = 4'b0010,
    LRM_WS_SECOND = 4'b0100,
    LRM_WS_RESET = 4'b1000
  } lrm_wdg_state_type;

endpackage
`default_nettype wire

//--- rtl/lrm_sync.sv
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes the input is a slow level such as a switch.
*/
`timescale 1ns/1ps
`default_nettype none
module lrm_sync (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  input wire logic rst_val_i,
  output logic sync_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_q <= rst_val_i;
      sync_q <= rst_val_i;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

//--- rtl/lrm_wdg.sv
/*
  Two-stage lockup watchdog countdown.
  Assumes reload strobes come from the register block on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lrm_wdg
  import lrm_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic kick_i,
  input wire logic [CNT_W-1:0] reload_i,
  output logic first_o,
  output logic second_o,
  output logic [CNT_W-1:0] count_o,
  output lrm_wdg_state_type state_o
);

  lrm_wdg_state_type state_q;
  lrm_wdg_state_type state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic first_q;
  logic first_d;
  logic second_q;
  logic second_d;

  // ----------------------------------------------------------------
  // Countdown and expiry stages
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    first_d = 1'b0;
    second_d = 1'b0;
    if (!enable_i) begin
      state_d = LRM_WS_IDLE;
      cnt_d = reload_i;
    end else if (kick_i) begin
      state_d = LRM_WS_IDLE;
      cnt_d = reload_i;
    end else begin
      case (state_q)
        LRM_WS_IDLE: begin
          if (cnt_q == '0) begin
            state_d = LRM_WS_FIRST;
            first_d = 1'b1;
            cnt_d = reload_i;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        LRM_WS_FIRST: begin
          if (cnt_q == '0) begin
            state_d = LRM_WS_RESET;
            second_d = 1'b1;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        default: begin
          state_d = LRM_WS_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= LRM_WS_IDLE;
      cnt_q <= '1;
      first_q <= 1'b0;
      second_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      first_q <= first_d;
      second_q <= second_d;
    end
  end

  assign first_o = first_q;
  assign second_o = second_q;
  assign count_o = cnt_q;
  assign state_o = state_q;

endmodule
`default_nettype wire

//--- rtl/lrm_top.sv
/*
  Lockup recovery manageability block: lockup watchdog, first-fetch check,
  ECC message routing, function disable and case intrusion, over APB.
  Assumes one 100 MHz clock, synchronous active-low reset, APB master.
*/
// Functional notes
// - First watchdog expiry raises a system management interrupt.
// - Second unserviced expiry triggers a full system reset.
// - After reset, reboot if the processor never fetches its first instruction.
// - ECC message from memory controller raises the selected interrupt type.
// - Separate disable bits for LAN, USB, LPC, audio, SATA, PCIe, SMBus.
// - Disabled function stops decoding I/O, memory and configuration space.
// - Disabled function produces no interrupts or power management events.
// - Intrusion input raises SMI or watchdog interrupt per programmable select.
`timescale 1ns/1ps
`default_nettype none
module lrm_top
  import lrm_pkg::*;
#(
  parameter int WDG_RELOAD_CYC = LRM_WDG_RELOAD_CYC,
  parameter int FETCH_WAIT_CYC = LRM_FETCH_WAIT_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic first_fetch_i,
  input wire lrm_ecc_msg_type ecc_msg_i,
  input wire logic intruder_n_i,
  input wire logic [LRM_FN_COUNT-1:0] fn_decode_i,
  input wire logic [LRM_FN_COUNT-1:0] fn_irq_i,
  input wire logic [LRM_FN_COUNT-1:0] fn_pme_i,
  output logic [LRM_FN_COUNT-1:0] fn_decode_en_o,
  output logic [LRM_FN_COUNT-1:0] fn_irq_o,
  output logic [LRM_FN_COUNT-1:0] fn_pme_o,
  output logic system_mgmt_interrupt_n_o,
  output logic nmi_o,
  output logic serr_n_o,
  output logic lockup_watchdog_irq_o,
  output logic sys_reset_n_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] reload_q, reload_d;
  logic [LRM_FN_COUNT-1:0] fndis_q, fndis_d;
  logic [LRM_ST_WIDTH-1:0] status_q, status_d;
  logic [LRM_ST_WIDTH-1:0] mask_q, mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic kick_q, kick_d;
  logic [31:0] fetch_cnt_q, fetch_cnt_d;
  logic fetch_wait_q, fetch_wait_d;
  logic fetch_fail_q, fetch_fail_d;
  logic [7:0] rst_cnt_q, rst_cnt_d;
  logic intr_prev_q, intr_prev_d;
  lrm_irq_type irq_q, irq_d;
  logic irq_out_q, irq_out_d;
  logic [LRM_FN_COUNT-1:0] dec_q, dec_d;
  logic [LRM_FN_COUNT-1:0] fnirq_q, fnirq_d;
  logic [LRM_FN_COUNT-1:0] fnpme_q, fnpme_d;
  logic smi_n_q, smi_n_d;
  logic serr_n_q, serr_n_d;
  logic sysrst_n_q, sysrst_n_d;

  logic wdg_first;
  logic wdg_second;
  logic [31:0] wdg_count;
  lrm_wdg_state_type wdg_state;
  logic intr_n_sync;
  logic fetch_sync;
  logic ecc_ev;
  logic intr_ev;
  logic wr_acc;
  logic rd_acc;
  logic [LRM_ST_WIDTH-1:0] ev;

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ofs);
    is_addr = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  lrm_wdg #(
    .CNT_W(32)
  ) u_wdg (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .enable_i(ctrl_q[LRM_CTRL_WDG_EN_BIT]),
    .kick_i(kick_q),
    .reload_i(reload_q),
    .first_o(wdg_first),
    .second_o(wdg_second),
    .count_o(wdg_count),
    .state_o(wdg_state)
  );

  lrm_sync u_intr_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(intruder_n_i),
    .rst_val_i(1'b1),
    .sync_o(intr_n_sync)
  );

  lrm_sync u_fetch_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(~first_fetch_i),
    .rst_val_i(1'b1),
    .sync_o(fetch_sync)
  );

  // ----------------------------------------------------------------
  // APB slave and register file
  // ----------------------------------------------------------------
  assign wr_acc = psel_i && penable_i && pwrite_i && !pready_q;
  assign rd_acc = psel_i && penable_i && !pwrite_i && !pready_q;
  assign ecc_ev = ecc_msg_i.valid;
  assign intr_ev = !intr_n_sync && intr_prev_q;

  always_comb begin
    ev = '0;
    ev[LRM_ST_WDG1_BIT] = wdg_first;
    ev[LRM_ST_WDG2_BIT] = wdg_second;
    ev[LRM_ST_FETCH_BIT] = fetch_fail_d && !fetch_fail_q;
    ev[LRM_ST_ECC_BIT] = ecc_ev;
    ev[LRM_ST_INTRUDE_BIT] = intr_ev;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    reload_d = reload_q;
    fndis_d = fndis_q;
    mask_d = mask_q;
    status_d = status_q;
    kick_d = 1'b0;
    prdata_d = prdata_q;
    pready_d = psel_i && penable_i && !pready_q;
    pslverr_d = 1'b0;
    if (wr_acc) begin
      if (is_addr(paddr_i, LRM_CTRL_OFS)) begin
        ctrl_d = {29'h0, pwdata_i[2:0]};
      end else if (is_addr(paddr_i, LRM_RELOAD_OFS)) begin
        reload_d = pwdata_i;
      end else if (is_addr(paddr_i, LRM_FUNCDIS_OFS)) begin
        fndis_d = pwdata_i[LRM_FN_COUNT-1:0];
      end else if (is_addr(paddr_i, LRM_STATUS_OFS)) begin
        status_d = status_q & ~pwdata_i[LRM_ST_WIDTH-1:0];
      end else if (is_addr(paddr_i, LRM_MASK_OFS)) begin
        mask_d = pwdata_i[LRM_ST_WIDTH-1:0];
      end else if (is_addr(paddr_i, LRM_KICK_OFS)) begin
        kick_d = 1'b1;
      end else if (!is_addr(paddr_i, LRM_COUNT_OFS) && !is_addr(paddr_i, LRM_STATE_OFS)) begin
        pslverr_d = 1'b1;
      end
    end
    if (rd_acc) begin
      if (is_addr(paddr_i, LRM_CTRL_OFS)) begin
        prdata_d = ctrl_q;
      end else if (is_addr(paddr_i, LRM_RELOAD_OFS)) begin
        prdata_d = reload_q;
      end else if (is_addr(paddr_i, LRM_COUNT_OFS)) begin
        prdata_d = wdg_count;
      end else if (is_addr(paddr_i, LRM_FUNCDIS_OFS)) begin
        prdata_d = {25'h0, fndis_q};
      end else if (is_addr(paddr_i, LRM_STATUS_OFS)) begin
        prdata_d = {27'h0, status_q};
      end else if (is_addr(paddr_i, LRM_MASK_OFS)) begin
        prdata_d = {27'h0, mask_q};
      end else if (is_addr(paddr_i, LRM_STATE_OFS)) begin
        prdata_d = {27'h0, !intr_n_sync, wdg_state};
      end else if (is_addr(paddr_i, LRM_KICK_OFS)) begin
        prdata_d = 32'h0;
      end else begin
        prdata_d = 32'h0;
        pslverr_d = 1'b1;
      end
    end
    status_d = status_d | ev;
  end

  // ----------------------------------------------------------------
  // First-fetch check and system reset
  // ----------------------------------------------------------------
  always_comb begin
    fetch_cnt_d = fetch_cnt_q;
    fetch_wait_d = fetch_wait_q;
    fetch_fail_d = fetch_fail_q;
    rst_cnt_d = rst_cnt_q;
    if (fetch_wait_q && ctrl_q[LRM_CTRL_FETCH_EN_BIT]) begin
      if (!fetch_sync) begin
        fetch_wait_d = 1'b0;
      end else if (fetch_cnt_q == 32'(FETCH_WAIT_CYC - 1)) begin
        fetch_fail_d = 1'b1;
        fetch_wait_d = 1'b0;
      end else begin
        fetch_cnt_d = fetch_cnt_q + 32'h1;
      end
    end
    if (wdg_second || (fetch_fail_d && !fetch_fail_q)) begin
      rst_cnt_d = 8'(LRM_RST_PULSE_CYC);
    end else if (rst_cnt_q != 8'h0) begin
      rst_cnt_d = rst_cnt_q - 8'h1;
    end
    sysrst_n_d = (rst_cnt_d == 8'h0);
  end

  // ----------------------------------------------------------------
  // Interrupt routing and function gating
  // ----------------------------------------------------------------
  always_comb begin
    intr_prev_d = intr_n_sync;
    irq_d.smi = wdg_first;
    irq_d.nmi = 1'b0;
    irq_d.serr = 1'b0;
    irq_d.wdg_irq = 1'b0;
    if (ecc_ev) begin
      case (ecc_msg_i.sel)
        LRM_ECC_SMI: irq_d.smi = 1'b1;
        LRM_ECC_NMI: irq_d.nmi = 1'b1;
        LRM_ECC_SERR: irq_d.serr = 1'b1;
        default: irq_d.wdg_irq = 1'b1;
      endcase
    end
    if (intr_ev) begin
      if (ctrl_q[LRM_CTRL_INTR_SEL_BIT]) begin
        irq_d.wdg_irq = 1'b1;
      end else begin
        irq_d.smi = 1'b1;
      end
    end
    irq_out_d = |(status_d & mask_q);
    dec_d = fn_decode_i & ~fndis_q;
    fnirq_d = fn_irq_i & ~fndis_q;
    fnpme_d = fn_pme_i & ~fndis_q;
    smi_n_d = ~irq_d.smi;
    serr_n_d = ~irq_d.serr;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= LRM_CTRL_RST;
      reload_q <= 32'(WDG_RELOAD_CYC);
      fndis_q <= LRM_FUNCDIS_RST;
      status_q <= '0;
      mask_q <= LRM_MASK_RST;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      kick_q <= 1'b0;
      fetch_cnt_q <= 32'h0;
      fetch_wait_q <= 1'b1;
      fetch_fail_q <= 1'b0;
      rst_cnt_q <= 8'h0;
      intr_prev_q <= 1'b1;
      irq_q <= '0;
      irq_out_q <= 1'b0;
      dec_q <= '0;
      fnirq_q <= '0;
      fnpme_q <= '0;
      smi_n_q <= 1'b1;
      serr_n_q <= 1'b1;
      sysrst_n_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      reload_q <= reload_d;
      fndis_q <= fndis_d;
      status_q <= status_d;
      mask_q <= mask_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      kick_q <= kick_d;
      fetch_cnt_q <= fetch_cnt_d;
      fetch_wait_q <= fetch_wait_d;
      fetch_fail_q <= fetch_fail_d;
      rst_cnt_q <= rst_cnt_d;
      intr_prev_q <= intr_prev_d;
      irq_q <= irq_d;
      irq_out_q <= irq_out_d;
      dec_q <= dec_d;
      fnirq_q <= fnirq_d;
      fnpme_q <= fnpme_d;
      smi_n_q <= smi_n_d;
      serr_n_q <= serr_n_d;
      sysrst_n_q <= sysrst_n_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign fn_decode_en_o = dec_q;
  assign fn_irq_o = fnirq_q;
  assign fn_pme_o = fnpme_q;
  assign system_mgmt_interrupt_n_o = smi_n_q;
  assign nmi_o = irq_q.nmi;
  assign serr_n_o = serr_n_q;
  assign lockup_watchdog_irq_o = irq_q.wdg_irq;
  assign sys_reset_n_o = sysrst_n_q;
  assign irq_o = irq_out_q;

endmodule
`default_nettype wire

//--- tb/lrm_checker.sv
/*
  Checker for lrm_top: APB answer timing, event routing, function gating
  and system reset pulse length. Bound to lrm_top, sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module lrm_checker
  import lrm_pkg::*;
#(
  parameter int WDG_RELOAD_CYC = 20,
  parameter int FETCH_WAIT_CYC = 50
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire lrm_ecc_msg_type ecc_msg_i,
  input wire logic [LRM_FN_COUNT-1:0] fn_decode_i,
  input wire logic [LRM_FN_COUNT-1:0] fn_irq_i,
  input wire logic [LRM_FN_COUNT-1:0] fn_pme_i,
  input wire logic [LRM_FN_COUNT-1:0] fn_decode_en_o,
  input wire logic [LRM_FN_COUNT-1:0] fn_irq_o,
  input wire logic [LRM_FN_COUNT-1:0] fn_pme_o,
  input wire logic system_mgmt_interrupt_n_o,
  input wire logic nmi_o,
  input wire logic serr_n_o,
  input wire logic lockup_watchdog_irq_o,
  input wire logic sys_reset_n_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Length of the system reset pulse
  // ----------------------------------------------------------------
  logic [4:0] low_q;
  logic [4:0] low_d;
  always_comb begin
    low_d = sys_reset_n_o ? 5'h00 : low_q + 5'h01;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) low_q <= 5'h00;
    else low_q <= low_d;
  end
  apb_answer_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access phase not answered next cycle");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready held more than one cycle");
  error_qual_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  ecc_smi_a: assert property (ecc_msg_i.valid && ecc_msg_i.sel == LRM_ECC_SMI
    |=> !system_mgmt_interrupt_n_o) else $error("ecc smi not raised");
  ecc_nmi_a: assert property (nmi_o |-> $past(ecc_msg_i.valid)
    && $past(ecc_msg_i.sel) == LRM_ECC_NMI) else $error("nmi without ecc message");
  ecc_serr_a: assert property (!serr_n_o |-> $past(ecc_msg_i.valid)
    && $past(ecc_msg_i.sel) == LRM_ECC_SERR) else $error("serr without ecc message");
  ecc_wdg_a: assert property (ecc_msg_i.valid && ecc_msg_i.sel == LRM_ECC_WDG
    |=> lockup_watchdog_irq_o) else $error("ecc watchdog irq not raised");
  decode_gate_a: assert property ((fn_decode_en_o & ~$past(fn_decode_i)) == '0)
    else $error("decode enable without request");
  event_gate_a: assert property ((fn_irq_o & ~$past(fn_irq_i)) == '0
    && (fn_pme_o & ~$past(fn_pme_i)) == '0) else $error("function event without request");
  reset_len_a: assert property ($rose(sys_reset_n_o) |-> low_q == 5'h10)
    else $error("system reset pulse not 16 cycles");
endmodule
`default_nettype wire

//--- tb/lrm_host_model.sv
/*
  Host side model: processor first fetch, memory controller ECC messages
  and chassis switch. Assumes tasks are called just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module lrm_host_model
  import lrm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sys_reset_n_i,
  input wire logic fetch_ok_i,
  output logic first_fetch_o,
  output lrm_ecc_msg_type ecc_msg_o,
  output logic intruder_n_o
);
  int boot_q;
  initial begin
    first_fetch_o = 1'b0;
    ecc_msg_o = '0;
    intruder_n_o = 1'b1;
    boot_q = 0;
  end
  // Processor fetches a few cycles after every reset unless held off
  always @(posedge mclk_i) begin
    if (!rst_n_i || !sys_reset_n_i) begin
      boot_q <= 0;
      first_fetch_o <= 1'b0;
    end else if (boot_q < 5) begin
      boot_q <= boot_q + 1;
    end else if (fetch_ok_i) begin
      first_fetch_o <= 1'b1;
    end
  end
  task automatic send_ecc(input lrm_ecc_type sel);
    ecc_msg_o <= '{valid: 1'b1, sel: sel};
    @(posedge mclk_i);
    ecc_msg_o <= '{valid: 1'b0, sel: lrm_ecc_type'(~sel)};
  endtask
  task automatic set_intruder(input logic open);
    intruder_n_o <= !open;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_lockup_recovery_manageability.sv
/*
  Testbench for lrm_top: registers, ECC routing, intrusion, watchdog,
  fetch check and function disable. Needs lrm_checker and lrm_host_model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_lockup_recovery_manageability;
  import lrm_pkg::*;
  localparam int WDG_CYC = 20;
  localparam int FETCH_CYC = 50;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fetch_ok = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, first_fetch, intruder_n;
  lrm_ecc_msg_type ecc_msg;
  logic [LRM_FN_COUNT-1:0] fn_in = '0, fn_dec, fn_irq, fn_pme;
  logic smi_n, nmi, serr_n, wdg_irq, sys_rst_n, irq;
  int ev[5] = '{default: 0};
  int base[5] = '{default: 0};
  int miscompares = 0, num_checks = 0, cycles = 0;
  always #5 mclk_i = ~mclk_i;
  lrm_top #(.WDG_RELOAD_CYC(WDG_CYC), .FETCH_WAIT_CYC(FETCH_CYC)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .first_fetch_i(first_fetch),
    .ecc_msg_i(ecc_msg), .intruder_n_i(intruder_n), .fn_decode_i(fn_in),
    .fn_irq_i(fn_in), .fn_pme_i(fn_in), .fn_decode_en_o(fn_dec), .fn_irq_o(fn_irq),
    .fn_pme_o(fn_pme), .system_mgmt_interrupt_n_o(smi_n), .nmi_o(nmi),
    .serr_n_o(serr_n), .lockup_watchdog_irq_o(wdg_irq), .sys_reset_n_o(sys_rst_n),
    .irq_o(irq));
  lrm_host_model u_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sys_reset_n_i(sys_rst_n),
    .fetch_ok_i(fetch_ok), .first_fetch_o(first_fetch), .ecc_msg_o(ecc_msg),
    .intruder_n_o(intruder_n));
  // ----------------------------------------------------------------
  // Event counters, timeout and tasks
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    cycles++;
    if (!smi_n) ev[0]++;
    if (nmi) ev[1]++;
    if (!serr_n) ev[2]++;
    if (wdg_irq) ev[3]++;
    if (!sys_rst_n) ev[4]++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_ev(input int e0, input int e1, input int e2, input int e3, input int e4);
    int exp[5];
    exp = '{e0, e1, e2, e3, e4};
    for (int i = 0; i < 5; i++) begin
      num_checks++;
      if (ev[i] - base[i] != exp[i]) begin
        miscompares++;
        $display("unexpected event %0d expected %0d seen %0d", i, exp[i], ev[i] - base[i]);
      end
    end
    base = ev;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    if (!experr) chk_val("read data", exp, r);
    chk_val("slave error", {31'h0, experr}, {31'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    tick(2);
    rst_n_i <= 1'b1;
    rd(LRM_CTRL_OFS, LRM_CTRL_RST, 1'b0);
    rd(LRM_FUNCDIS_OFS, 32'h0, 1'b0);
    rd(LRM_MASK_OFS, 32'h0, 1'b0);
    rd(LRM_STATUS_OFS, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    fn_in <= 7'h7f;
    for (int i = 0; i < LRM_FN_COUNT; i++) begin
      wr(LRM_FUNCDIS_OFS, 32'h1 << i);
      tick(2);
      chk_val("decode enable", {25'h0, ~(7'h01 << i)}, {25'h0, fn_dec});
      chk_val("function irq", {25'h0, ~(7'h01 << i)}, {25'h0, fn_irq});
      chk_val("function pme", {25'h0, ~(7'h01 << i)}, {25'h0, fn_pme});
    end
    wr(LRM_MASK_OFS, 32'h8);
    for (int s = 0; s < 4; s++) begin
      base = ev;
      u_host.send_ecc(lrm_ecc_type'(s));
      tick(3);
      chk_ev(int'(s == 0), int'(s == 1), int'(s == 2), int'(s == 3), 0);
      chk_val("irq line", 32'h1, {31'h0, irq});
      rd(LRM_STATUS_OFS, 32'h8, 1'b0);
      wr(LRM_STATUS_OFS, 32'h8);
      tick(2);
      chk_val("irq line", 32'h0, {31'h0, irq});
    end
    for (int s = 0; s < 2; s++) begin
      wr(LRM_CTRL_OFS, LRM_CTRL_RST | (32'(s) << LRM_CTRL_INTR_SEL_BIT));
      base = ev;
      u_host.set_intruder(1'b1);
      tick(6);
      u_host.set_intruder(1'b0);
      tick(6);
      chk_ev(int'(s == 0), 0, 0, int'(s == 1), 0);
      chk_val("masked irq line", 32'h0, {31'h0, irq});
      rd(LRM_STATUS_OFS, 32'h10, 1'b0);
      wr(LRM_STATUS_OFS, 32'h10);
      rd(LRM_STATUS_OFS, 32'h0, 1'b0);
    end
    wr(LRM_CTRL_OFS, LRM_CTRL_RST);
    wr(LRM_RELOAD_OFS, 32'(WDG_CYC));
    rd(LRM_RELOAD_OFS, 32'(WDG_CYC), 1'b0);
    rd(LRM_COUNT_OFS, 32'(WDG_CYC), 1'b0);
    wr(LRM_CTRL_OFS, LRM_CTRL_RST | 32'h1);
    base = ev;
    repeat (6) begin
      wr(LRM_KICK_OFS, 32'h0);
      tick(5);
    end
    chk_ev(0, 0, 0, 0, 0);
    tick(26);
    chk_ev(1, 0, 0, 0, 0);
    wr(LRM_KICK_OFS, 32'h0);
    tick(26);
    chk_ev(1, 0, 0, 0, 0);
    tick(20);
    wr(LRM_CTRL_OFS, LRM_CTRL_RST);
    tick(20);
    chk_ev(0, 0, 0, 0, 16);
    rd(LRM_STATUS_OFS, 32'h3, 1'b0);
    wr(LRM_STATUS_OFS, 32'h3);
    fetch_ok <= 1'b0;
    rst_n_i <= 1'b0;
    tick(3);
    rst_n_i <= 1'b1;
    base = ev;
    for (int k = 0; k < FETCH_CYC + 100 && sys_rst_n !== 1'b0; k++) tick(1);
    fetch_ok <= 1'b1;
    tick(40);
    chk_ev(0, 0, 0, 0, 16);
    rd(LRM_STATUS_OFS, 32'h4, 1'b0);
    tally_and_finish();
  end
endmodule
bind lrm_top lrm_checker #(.WDG_RELOAD_CYC(WDG_RELOAD_CYC), .FETCH_WAIT_CYC(FETCH_WAIT_CYC))
  u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .ecc_msg_i(ecc_msg_i),
  .fn_decode_i(fn_decode_i), .fn_irq_i(fn_irq_i), .fn_pme_i(fn_pme_i),
  .fn_decode_en_o(fn_decode_en_o), .fn_irq_o(fn_irq_o), .fn_pme_o(fn_pme_o),
  .system_mgmt_interrupt_n_o(system_mgmt_interrupt_n_o), .nmi_o(nmi_o),
  .serr_n_o(serr_n_o), .lockup_watchdog_irq_o(lockup_watchdog_irq_o),
  .sys_reset_n_o(sys_reset_n_o));
`default_nettype wire
